// >>> acmp_calc.sv
// scaling, difference and threshold decision, purely combinational
`timescale 1ns/100ps
module acmp_calc #(
   parameter int IN_W = 16
) (
   acmp_eval_if.calc ev
);
   import acmp_pkg::*;

   acmp_val_t sa;
   acmp_val_t sb;
   acmp_val_t on_v;
   acmp_val_t off_v;

   always_comb begin
      // [R1] same gain and offset
      sa = acmp_scale(32'(ev.a), ev.gain, ev.offset);
      sb = acmp_scale(32'(ev.b), ev.gain, ev.offset);
      // [R2] first minus second
      ev.diff = sa - sb;
      on_v = ACMP_VAL_W'(ev.on_thr);
      off_v = ACMP_VAL_W'(ev.off_thr);
      // [R5] raw integers, no decimals
      if (on_v >= off_v) begin
         // [R3] hysteresis mode
         if (ev.diff > on_v) begin
            ev.q_next = 1'b1;
         end else if (ev.diff <= off_v) begin
            ev.q_next = 1'b0;
         end else begin
            // [R10] hold between thresholds
            ev.q_next = ev.q_prev;
         end
      end else begin
         // [R4] window mode
         ev.q_next = (ev.diff >= on_v) && (ev.diff < off_v);
      end
   end
endmodule // acmp_calc

// >>> acmp_eval_if.sv
// operands and results passed between control and arithmetic
`timescale 1ns/100ps
interface acmp_eval_if #(parameter int IN_W = 16);
   import acmp_pkg::*;
   logic signed [IN_W-1:0] a;
   logic signed [IN_W-1:0] b;
   acmp_par_t gain;
   acmp_par_t offset;
   acmp_par_t on_thr;
   acmp_par_t off_thr;
   logic q_prev;
   acmp_val_t diff;
   logic q_next;

   modport calc (
      input a,
      input b,
      input gain,
      input offset,
      input on_thr,
      input off_thr,
      input q_prev,
      output diff,
      output q_next
   );
   modport ctl (
      output a,
      output b,
      output gain,
      output offset,
      output on_thr,
      output off_thr,
      output q_prev,
      input diff,
      input q_next
   );
endinterface

// >>> acmp_pkg.sv
// shared constants, types and scaling arithmetic of the comparator
package acmp_pkg;
   typedef logic signed [15:0] acmp_par_t;
   typedef logic signed [33:0] acmp_val_t;

   localparam int ACMP_PAR_W = 16;
   localparam int ACMP_VAL_W = 34;
   localparam int ACMP_ADDR_W = 8;

   // register byte offsets
   localparam logic [7:0] ACMP_OFS_GAIN = 8'h00;
   localparam logic [7:0] ACMP_OFS_OFFSET = 8'h04;
   localparam logic [7:0] ACMP_OFS_ON_THR = 8'h08;
   localparam logic [7:0] ACMP_OFS_OFF_THR = 8'h0C;
   localparam logic [7:0] ACMP_OFS_DECIMALS = 8'h10;
   localparam logic [7:0] ACMP_OFS_STATUS = 8'h14;
   localparam logic [7:0] ACMP_OFS_DIFF = 8'h18;

   // field positions
   localparam int ACMP_STATUS_Q_BIT = 0;
   localparam int ACMP_DEC_W = 2;

   // reset values
   localparam acmp_par_t ACMP_RST_GAIN = 16'sh0000;
   localparam acmp_par_t ACMP_RST_OFFSET = 16'sh0000;
   localparam acmp_par_t ACMP_RST_ON_THR = 16'sh0000;
   localparam acmp_par_t ACMP_RST_OFF_THR = 16'sh0000;
   localparam logic [1:0] ACMP_RST_DECIMALS = 2'h0;

   // gain carries two fractional decimal digits
   localparam logic signed [47:0] ACMP_GAIN_DIV = 48'sh64;

   localparam logic [1:0] ACMP_RESP_OKAY = 2'h0;
   localparam logic [1:0] ACMP_RESP_SLVERR = 2'h2;

   // (x * gain) / 100 + offset, truncated toward zero
   function automatic acmp_val_t acmp_scale(input logic signed [31:0] x,
                                            input acmp_par_t gain,
                                            input acmp_par_t offset);
      logic signed [47:0] prod;
      prod = 48'(x) * 48'(gain);
      return ACMP_VAL_W'(prod / ACMP_GAIN_DIV) + ACMP_VAL_W'(offset);
   endfunction

   // byte-lane merge of a write into an old word
   function automatic logic [31:0] acmp_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction
endpackage

// >>> acmp_src.sv
// analog source model driving both comparator inputs
`timescale 1ns/100ps
module acmp_src #(
   parameter int IN_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic signed [IN_W-1:0] want_a,
   input wire logic signed [IN_W-1:0] want_b,
   output logic signed [IN_W-1:0] first_analog_input,
   output logic signed [IN_W-1:0] second_analog_input
);
   // channels settle one sample after a request, like a real converter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_analog_input <= '0;
         second_analog_input <= '0;
      end else begin
         first_analog_input <= want_a;
         second_analog_input <= want_b;
      end
   end
endmodule // acmp_src

// >>> acmp_top.sv
// scaled difference comparator with an axi4-lite register slave
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
// Contract
// [R1] both inputs scaled by one signed gain, then one signed offset added
// [R2] difference is first actual value minus second actual value
// [R3] on at or above off: set above on, clear at or below off
// [R4] on below off: high only while on <= difference < off
// [R5] comparison uses raw integers; decimals setting is display only
// [R6] configuring party keeps gain within -10.00 to 10.00
// [R7] configuring party keeps offset within -10000 to 10000
// [R8] configuring party keeps both thresholds within -20000 to 20000
// [R9] configuring party keeps decimals at 0, 1, 2 or 3
// [R10] output registered per evaluation, holds between thresholds, resets low
module acmp_top #(
   parameter int IN_W = 16,
   parameter int ADDR_W = acmp_pkg::ACMP_ADDR_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic signed [IN_W-1:0] first_analog_input,
   input wire logic signed [IN_W-1:0] second_analog_input,
   input wire logic eval_strobe,
   output logic comparator_out,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import acmp_pkg::*;

   if (IN_W < 2 || IN_W > 24) begin : g_bad_in_w
      $error("acmp_top: IN_W must lie in 2..24, difference is 34 bits");
   end
   if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
      $error("acmp_top: ADDR_W must lie in 5..32");
   end

   acmp_eval_if #(.IN_W(IN_W)) ev ();

   acmp_par_t gain_q, gain_d;
   acmp_par_t offset_q, offset_d;
   acmp_par_t on_q, on_d;
   acmp_par_t off_q, off_d;
   logic [1:0] dec_q, dec_d;
   logic q_q, q_d;
   acmp_val_t diff_q, diff_d;
   logic aw_full_q, aw_full_d;
   logic [7:0] aw_addr_q, aw_addr_d;
   logic w_full_q, w_full_d;
   logic [31:0] w_data_q, w_data_d;
   logic [3:0] w_strb_q, w_strb_d;
   logic awready_q, awready_d;
   logic wready_q, wready_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [1:0] rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic commit;
   logic [31:0] wv;
   logic [7:0] raddr;
   assign ev.a = first_analog_input;
   assign ev.b = second_analog_input;
   assign ev.gain = gain_q;
   assign ev.offset = offset_q;
   assign ev.on_thr = on_q;
   assign ev.off_thr = off_q;
   assign ev.q_prev = q_q;

   acmp_calc #(.IN_W(IN_W)) u_calc (
      .ev(ev.calc)
   );

   // evaluation and register writes
   always_comb begin
      gain_d = gain_q;
      offset_d = offset_q;
      on_d = on_q;
      off_d = off_q;
      dec_d = dec_q;
      q_d = q_q;
      diff_d = diff_q;
      wv = 32'h0000_0000;
      // [R10] one update per evaluation
      if (eval_strobe) begin
         q_d = ev.q_next;
         diff_d = ev.diff;
      end
      commit = aw_full_q && w_full_q && !bvalid_q;
      if (commit) begin
         case (aw_addr_q)
            ACMP_OFS_GAIN: begin
               wv = acmp_merge(32'(gain_q), w_data_q, w_strb_q);
               gain_d = wv[15:0];
            end
            ACMP_OFS_OFFSET: begin
               wv = acmp_merge(32'(offset_q), w_data_q, w_strb_q);
               offset_d = wv[15:0];
            end
            ACMP_OFS_ON_THR: begin
               wv = acmp_merge(32'(on_q), w_data_q, w_strb_q);
               on_d = wv[15:0];
            end
            ACMP_OFS_OFF_THR: begin
               wv = acmp_merge(32'(off_q), w_data_q, w_strb_q);
               off_d = wv[15:0];
            end
            ACMP_OFS_DECIMALS: begin
               // [R5] stored for display only
               wv = acmp_merge(32'(dec_q), w_data_q, w_strb_q);
               dec_d = wv[1:0];
            end
            default: begin
               wv = 32'h0000_0000;
            end
         endcase
      end
   end

   // write channels: address and data taken in either order
   always_comb begin
      aw_full_d = aw_full_q;
      aw_addr_d = aw_addr_q;
      w_full_d = w_full_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (s_axi_awvalid && awready_q) begin
         aw_full_d = 1'b1;
         aw_addr_d = 8'({s_axi_awaddr[ADDR_W-1:2], 2'b00});
      end
      if (s_axi_wvalid && wready_q) begin
         w_full_d = 1'b1;
         w_data_d = s_axi_wdata;
         w_strb_d = s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (commit) begin
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
         bvalid_d = 1'b1;
         case (aw_addr_q)
            ACMP_OFS_GAIN, ACMP_OFS_OFFSET, ACMP_OFS_ON_THR,
            ACMP_OFS_OFF_THR, ACMP_OFS_DECIMALS: bresp_d = ACMP_RESP_OKAY;
            default: bresp_d = ACMP_RESP_SLVERR;
         endcase
      end
      // no new write until the response is taken
      awready_d = !aw_full_d && !bvalid_d;
      wready_d = !w_full_d && !bvalid_d;
   end

   // read channel: data answered one edge after the address
   always_comb begin
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      raddr = 8'({s_axi_araddr[ADDR_W-1:2], 2'b00});
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rresp_d = ACMP_RESP_OKAY;
         case (raddr)
            ACMP_OFS_GAIN: rdata_d = 32'(gain_q);
            ACMP_OFS_OFFSET: rdata_d = 32'(offset_q);
            ACMP_OFS_ON_THR: rdata_d = 32'(on_q);
            ACMP_OFS_OFF_THR: rdata_d = 32'(off_q);
            ACMP_OFS_DECIMALS: rdata_d = 32'(dec_q);
            ACMP_OFS_STATUS: rdata_d = 32'(q_q) << ACMP_STATUS_Q_BIT;
            ACMP_OFS_DIFF: rdata_d = diff_q[31:0];
            default: begin
               rdata_d = 32'h0000_0000;
               rresp_d = ACMP_RESP_SLVERR;
            end
         endcase
      end
      arready_d = !rvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gain_q <= ACMP_RST_GAIN;
         offset_q <= ACMP_RST_OFFSET;
         on_q <= ACMP_RST_ON_THR;
         off_q <= ACMP_RST_OFF_THR;
         dec_q <= ACMP_RST_DECIMALS;
         // [R10] output low from reset
         q_q <= 1'b0;
         diff_q <= 34'sh0;
         aw_full_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_full_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= ACMP_RESP_OKAY;
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rresp_q <= ACMP_RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else begin
         gain_q <= gain_d;
         offset_q <= offset_d;
         on_q <= on_d;
         off_q <= off_d;
         dec_q <= dec_d;
         q_q <= q_d;
         diff_q <= diff_d;
         aw_full_q <= aw_full_d;
         aw_addr_q <= aw_addr_d;
         w_full_q <= w_full_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   assign comparator_out = q_q;
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;

   // checks, reference arithmetic kept apart from the calc instance
   sequence s_eval_hyst;
      eval_strobe && (on_q >= off_q);
   endsequence
   sequence s_eval_win;
      eval_strobe && (on_q < off_q);
   endsequence
   acmp_val_t exp_diff;
   logic exp_win;
   assign exp_diff = acmp_scale(32'(first_analog_input), gain_q, offset_q)
      - acmp_scale(32'(second_analog_input), gain_q, offset_q);
   assign exp_win = (exp_diff >= ACMP_VAL_W'(on_q))
      && (exp_diff < ACMP_VAL_W'(off_q));

   a_scaled_diff: assert property (@(posedge aclk) // [R1]
      disable iff (!aresetn) eval_strobe |=> diff_q == $past(exp_diff))
      else $error("difference not scaled first minus second");
   a_hyst_set: assert property (@(posedge aclk) // [R3]
      disable iff (!aresetn)
      s_eval_hyst ##0 (exp_diff > ACMP_VAL_W'(on_q)) |=> comparator_out)
      else $error("output not set above on threshold");
   a_hyst_clear: assert property (@(posedge aclk) // [R3]
      disable iff (!aresetn)
      s_eval_hyst ##0 (exp_diff <= ACMP_VAL_W'(off_q)) |=> !comparator_out)
      else $error("output not cleared at or below off threshold");
   a_hyst_hold: assert property (@(posedge aclk) // [R10]
      disable iff (!aresetn) s_eval_hyst ##0 (exp_diff > ACMP_VAL_W'(off_q))
         ##0 (exp_diff <= ACMP_VAL_W'(on_q)) |=> $stable(comparator_out))
      else $error("output moved between thresholds");
   a_window_out: assert property (@(posedge aclk) // [R4]
      disable iff (!aresetn) s_eval_win |=> comparator_out == $past(exp_win))
      else $error("window output wrong");
   a_idle_stable: assert property (@(posedge aclk) // [R10]
      disable iff (!aresetn)
      !eval_strobe |=> $stable(comparator_out) && $stable(diff_q))
      else $error("output changed without evaluation");
   a_reset_low: assert property (@(posedge aclk) // [R10]
      !aresetn |=> !comparator_out)
      else $error("output not low after reset");
   a_dec_ignored: assert property (@(posedge aclk) // [R5]
      disable iff (!aresetn) s_eval_hyst ##0 (dec_q != ACMP_RST_DECIMALS)
         ##0 (exp_diff > ACMP_VAL_W'(on_q)) |=> comparator_out)
      else $error("decimals setting changed the decision");
endmodule // acmp_top

// >>> acmp_top_tb.sv
// self-checking bench for the scaled difference comparator
`timescale 1ns/100ps
module acmp_top_tb;
   import acmp_pkg::*;
   logic aclk, aresetn, eval_strobe, comparator_out;
   logic signed [15:0] want_a, want_b, ain_a, ain_b;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int num_errors = 0, check_count = 0, cycles = 0, seed = 36908;
   int cg, co, con, coff;
   logic exp_q;
   int hy[8] = '{20, 10, 15, 5, 6, 16, -3, 30};
   int wi[6] = '{-11, -10, 9, 10, 0, 11};

   acmp_src u_acmp_src (.aclk, .aresetn, .want_a, .want_b,
      .first_analog_input(ain_a), .second_analog_input(ain_b));
   acmp_top u_acmp_top (.aclk, .aresetn, .first_analog_input(ain_a),
      .second_analog_input(ain_b), .eval_strobe, .comparator_out,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er), "bresp");
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed, "rdata");
      chk(32'(s_axi_rresp), 32'(er), "rresp");
      @(posedge aclk);
   endtask

   // expected actual value, truncating the hundredths of gain
   function automatic logic signed [33:0] act(input int x);
      longint p;
      p = longint'(x) * cg;
      return 34'(p / 100 + co);
   endfunction

   task automatic cfg(input int g, input int o, input int on, input int off);
      cg = g;
      co = o;
      con = on;
      coff = off;
      wr(ACMP_OFS_GAIN, 32'(g), ACMP_RESP_OKAY);
      wr(ACMP_OFS_OFFSET, 32'(o), ACMP_RESP_OKAY);
      wr(ACMP_OFS_ON_THR, 32'(on), ACMP_RESP_OKAY);
      wr(ACMP_OFS_OFF_THR, 32'(off), ACMP_RESP_OKAY);
   endtask

   task automatic ev(input logic signed [15:0] a, input logic signed [15:0] b);
      logic signed [33:0] d;
      want_a <= a;
      want_b <= b;
      @(posedge aclk);
      eval_strobe <= 1'b1;
      @(posedge aclk);
      eval_strobe <= 1'b0;
      d = act(int'(a)) - act(int'(b));
      if (con >= coff) begin
         exp_q = (d > con) ? 1'b1 : ((d <= coff) ? 1'b0 : exp_q);
      end else begin
         exp_q = (d >= con) && (d < coff);
      end
      @(posedge aclk);
      chk(32'(comparator_out), 32'(exp_q), "out");
      rd(ACMP_OFS_DIFF, d[31:0], ACMP_RESP_OKAY);
      rd(ACMP_OFS_STATUS, 32'(exp_q), ACMP_RESP_OKAY);
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // ceiling well above the roughly 1400 cycles the tests need
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         $display("[ERR] %0t timeout", $time);
         stop_test();
      end
   end

   initial begin
      aresetn = 1'b0;
      eval_strobe = 1'b0;
      want_a = '0;
      want_b = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      exp_q = 1'b0;
      cg = 0;
      co = 0;
      con = 0;
      coff = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rd(8'(i * 4), 32'h0, ACMP_RESP_OKAY);
      end
      chk(32'(comparator_out), 32'h0, "reset out");
      $display("test reset done");
      rd(8'h1C, 32'h0, ACMP_RESP_SLVERR);
      wr(8'h40, 32'h1234, ACMP_RESP_SLVERR);
      wr(ACMP_OFS_STATUS, 32'h1, ACMP_RESP_SLVERR);
      wr(ACMP_OFS_GAIN, 32'h0000FF9C, ACMP_RESP_OKAY);
      rd(ACMP_OFS_GAIN, 32'hFFFFFF9C, ACMP_RESP_OKAY);
      $display("test register map done");
      cfg(100, 0, 15, 5);
      foreach (hy[i]) ev(16'(hy[i]), 16'sh0);
      wr(ACMP_OFS_DECIMALS, 32'h3, ACMP_RESP_OKAY);
      ev(16'sh10, 16'sh0);
      cfg(10, -30, 15, 5);
      ev(16'sh190, 16'sh64);
      $display("test hysteresis done");
      // mid-run reset while the output is high must clear it
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      exp_q = 1'b0;
      @(posedge aclk);
      chk(32'(comparator_out), 32'h0, "mid reset out");
      rd(ACMP_OFS_STATUS, 32'h0, ACMP_RESP_OKAY);
      rd(ACMP_OFS_ON_THR, 32'h0, ACMP_RESP_OKAY);
      $display("test mid reset done");
      cfg(100, 0, -10, 10);
      foreach (wi[i]) ev(16'(wi[i]), 16'sh0);
      $display("test window done");
      // config kept inside the ranges the configuring side must respect
      for (int i = 0; i < 40; i++) begin
         wr(ACMP_OFS_DECIMALS, 32'($random(seed) & 3), ACMP_RESP_OKAY);
         cfg($random(seed) % 1001, $random(seed) % 10001,
             $random(seed) % 20001, $random(seed) % 20001);
         ev(16'($random(seed)), 16'($random(seed)));
      end
      $display("test random done");
      stop_test();
   end
endmodule // acmp_top_tb
